/* include/cmd_pkg.sv */
// Shared constants, types and checksum step of the compass host command interpreter.
// Assumes a byte-wide receiver and transmitter on the same clock as the interpreter.
package cmd_pkg;
  localparam int RX_MAX = 16;
  localparam int TX_MAX = 20;
  localparam int COMP_MAX = 3;
  localparam int CN_W = 2;
  localparam int IDENT_LEN = 8;
  localparam int COMP_BYTES = 5;
  localparam int POS_LEN_HI = 0;
  localparam int POS_LEN_LO = 1;
  localparam int POS_ID = 2;
  localparam int POS_PAY = 3;
  localparam logic [7:0] ID_IDENT_REQ = 8'h01;
  localparam logic [7:0] ID_IDENT_RSP = 8'h02;
  localparam logic [7:0] ID_OUT_SEL = 8'h03;
  localparam logic [7:0] ID_SAMPLE_REQ = 8'h04;
  localparam logic [7:0] ID_SAMPLE_RSP = 8'h05;
  localparam logic [7:0] ID_CFG_WRITE = 8'h06;
  localparam logic [7:0] ID_CFG_READ = 8'h07;
  localparam logic [7:0] ID_CFG_RESP = 8'h08;
  localparam logic [7:0] ID_PERSIST = 8'h09;
  localparam logic [7:0] ID_SLEEP_REQ = 8'h0F;
  localparam logic [7:0] ID_CFG_ACK = 8'h13;
  localparam logic [7:0] ID_WAKE_ACK = 8'h17;
  localparam logic [7:0] ID_SLEEP_ACK = 8'h1C;
  localparam logic [7:0] CFG_MAG_SET = 8'h12;
  localparam logic [7:0] CFG_ACCEL_SET = 8'h13;
  localparam logic [7:0] COMP_HEADING = 8'h05;
  localparam logic [7:0] COMP_PITCH = 8'h18;
  localparam logic [7:0] COMP_ROLL = 8'h19;
  localparam logic [31:0] MAG_SET_LAST = 32'h0000_0007;
  localparam logic [31:0] ACCEL_SET_LAST = 32'h0000_0002;
  // Count bytes, identifier byte and two checksum bytes.
  localparam logic [7:0] FRAME_OVERHEAD = 8'h05;
  localparam logic [7:0] LEN_CFG = 8'h0A;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [3:0] {
    S_RX = 4'h1,
    S_EXEC = 4'h2,
    S_TX = 4'h4,
    S_SLEEP = 4'h8
  } state_t;

  typedef struct packed {
    logic [31:0] heading;
    logic [31:0] pitch;
    logic [31:0] roll;
  } sample_t;

  typedef struct packed {
    logic [2:0] mag;
    logic [2:0] accel;
  } coeff_sel_t;

  typedef struct packed {
    state_t st;
    logic [RX_MAX-1:0][7:0] rx_buf;
    logic [7:0] rx_cnt;
    logic [15:0] rx_crc;
    logic [TX_MAX-1:0][7:0] tx_buf;
    logic [7:0] tx_len;
    logic [7:0] tx_idx;
    logic [7:0] tx_byte;
    logic [15:0] tx_crc;
    logic sleep_after;
    logic awake;
    coeff_sel_t sel;
    logic [CN_W-1:0] comp_n;
    logic [COMP_MAX-1:0][7:0] comp_id;
    logic persist;
    logic cal_store;
    logic [2:0] cal_set;
    logic rx_meta;
    logic rx_sync;
  } core_t;

  function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc16_step
endpackage : cmd_pkg

/* hdl/compass_host_command_protocol.sv */
// Framed host command interpreter: parses frames, answers them, handles sleep and wake.
// Assumes a byte receiver and transmitter on this clock and the raw receive pin for wake.
`timescale 1ns/1ps

// Contract
// - A sleep request frame powers down sensors, processor and driver, keeping receive on; here only sensors_on drops, and only rx_pin is watched.
// - A sleep request is confirmed with an empty sleep_ack_frame.
// - While asleep, any activity on the receive pin wakes the device fully.
// - After waking the device sends an empty wake_ack_frame.
// - A config write of magnetometer_set_select with value 0 to 7 selects that set.
// - Every accepted config write is answered by an empty frame with identifier 0x13.
// - A config read is answered with the identifier echoed and its four-byte value; here only CFG_MAG_SET and CFG_ACCEL_SET reads get one.
// - An empty persist_frame saves the configuration to flash.
// - Finished calibration coefficients go to the selected magnetometer set.
// - An ident_request_frame is answered with an ASCII type and version string.
// - An output_selection_frame holds a count and then component identifiers.
// - A sample_request_frame is answered with the count, then each identifier and value.
module compass_host_command_protocol #(
  // Identification string; the value is arbitrary.
  parameter logic [8*cmd_pkg::IDENT_LEN-1:0] IDENT = 64'h4D4F_4445_4C30_3031
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic rx_pin,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_ready,
  input wire cmd_pkg::sample_t sample,
  input wire logic cal_done,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic sensors_on,
  output cmd_pkg::coeff_sel_t coeff_sel,
  output logic persist_strobe,
  output logic cal_store_strobe,
  output logic [2:0] cal_store_set
);
  cmd_pkg::core_t s_q;
  cmd_pkg::core_t s_d;
  logic rsp_send;
  logic [7:0] rsp_id;
  logic [7:0] rsp_len;
  logic [15:0] rx_len_n;
  logic [15:0] rx_crc_n;
  logic [7:0] rx_cnt_n;
  logic [7:0] tx_nx;
  logic [15:0] tx_crc_n;
  logic [7:0] rx_id;
  logic [7:0] cfg_id;
  logic [31:0] cfg_val;
  logic [2:0] cfg_low3;
  logic cfg_len_ok;
  logic mag_ok;
  logic accel_ok;
  logic cfg_known;
  logic sel_ok;
  logic [31:0] val;

  function automatic logic [31:0] comp_value(input logic [7:0] id, input cmd_pkg::sample_t s);
    case (id)
      cmd_pkg::COMP_HEADING: return s.heading;
      cmd_pkg::COMP_PITCH: return s.pitch;
      cmd_pkg::COMP_ROLL: return s.roll;
      default: return 32'h0000_0000;
    endcase
  endfunction : comp_value

  assign rx_id = s_q.rx_buf[cmd_pkg::POS_ID];
  assign cfg_id = s_q.rx_buf[cmd_pkg::POS_PAY];
  assign cfg_val = {s_q.rx_buf[cmd_pkg::POS_PAY+1], s_q.rx_buf[cmd_pkg::POS_PAY+2],
                    s_q.rx_buf[cmd_pkg::POS_PAY+3], s_q.rx_buf[cmd_pkg::POS_PAY+4]};
  assign cfg_low3 = cfg_val[2:0];
  assign cfg_len_ok = (s_q.rx_buf[cmd_pkg::POS_LEN_LO] == cmd_pkg::LEN_CFG);
  // Out-of-range set numbers are refused silently rather than clipped.
  assign mag_ok = cfg_len_ok && cfg_id == cmd_pkg::CFG_MAG_SET && cfg_val <= cmd_pkg::MAG_SET_LAST;
  assign accel_ok = cfg_len_ok && cfg_id == cmd_pkg::CFG_ACCEL_SET
                    && cfg_val <= cmd_pkg::ACCEL_SET_LAST;
  assign cfg_known = cfg_id == cmd_pkg::CFG_MAG_SET || cfg_id == cmd_pkg::CFG_ACCEL_SET;
  assign sel_ok = cfg_id <= 8'(cmd_pkg::COMP_MAX);
  assign rx_len_n = {s_q.rx_buf[cmd_pkg::POS_LEN_HI], rx_byte};
  assign rx_crc_n = cmd_pkg::crc16_step(s_q.rx_crc, rx_byte);
  assign rx_cnt_n = s_q.rx_cnt + 8'h01;
  assign tx_nx = s_q.tx_idx + 8'h01;
  assign tx_crc_n = cmd_pkg::crc16_step(s_q.tx_crc, s_q.tx_byte);

  always_comb begin
    s_d = s_q;
    rsp_send = 1'b0;
    rsp_id = 8'h00;
    rsp_len = cmd_pkg::FRAME_OVERHEAD;
    val = 32'h0000_0000;
    s_d.rx_meta = rx_pin;
    s_d.rx_sync = s_q.rx_meta;
    s_d.persist = 1'b0;
    s_d.cal_store = 1'b0;
    if (cal_done) begin
      s_d.cal_store = 1'b1;
      s_d.cal_set = s_q.sel.mag;
    end
    case (s_q.st)
      cmd_pkg::S_RX: begin
        // Bytes are taken only here; anything arriving while busy or asleep is lost.
        if (rx_valid) begin
          s_d.rx_crc = rx_crc_n;
          s_d.rx_cnt = rx_cnt_n;
          if (s_q.rx_cnt < 8'(cmd_pkg::RX_MAX)) begin
            s_d.rx_buf[s_q.rx_cnt] = rx_byte;
          end
          if (s_q.rx_cnt == 8'(cmd_pkg::POS_LEN_LO)
              && (rx_len_n < 16'(cmd_pkg::FRAME_OVERHEAD)
                  || rx_len_n > 16'(cmd_pkg::RX_MAX))) begin
            s_d.rx_cnt = 8'h00;
            s_d.rx_crc = cmd_pkg::CRC_INIT;
          end else if (s_q.rx_cnt > 8'(cmd_pkg::POS_LEN_LO)
                       && rx_cnt_n == s_q.rx_buf[cmd_pkg::POS_LEN_LO]) begin
            s_d.rx_cnt = 8'h00;
            s_d.rx_crc = cmd_pkg::CRC_INIT;
            // A checksum over the whole frame, its own two bytes included, leaves zero.
            if (rx_crc_n == cmd_pkg::CRC_INIT) begin
              s_d.st = cmd_pkg::S_EXEC;
            end
          end
        end
      end
      cmd_pkg::S_EXEC: begin
        s_d.st = cmd_pkg::S_RX;
        case (rx_id)
          cmd_pkg::ID_IDENT_REQ: begin
            rsp_send = 1'b1;
            rsp_id = cmd_pkg::ID_IDENT_RSP;
            rsp_len = cmd_pkg::FRAME_OVERHEAD + 8'(cmd_pkg::IDENT_LEN);
            for (int i = 0; i < cmd_pkg::IDENT_LEN; i++) begin
              s_d.tx_buf[cmd_pkg::POS_PAY+i] = IDENT[8*(cmd_pkg::IDENT_LEN-1-i) +: 8];
            end
          end
          cmd_pkg::ID_OUT_SEL: begin
            if (sel_ok) begin
              s_d.comp_n = cfg_id[cmd_pkg::CN_W-1:0];
              for (int i = 0; i < cmd_pkg::COMP_MAX; i++) begin
                s_d.comp_id[i] = s_q.rx_buf[cmd_pkg::POS_PAY+1+i];
              end
            end
          end
          cmd_pkg::ID_SAMPLE_REQ: begin
            rsp_send = 1'b1;
            rsp_id = cmd_pkg::ID_SAMPLE_RSP;
            rsp_len = cmd_pkg::FRAME_OVERHEAD + 8'h01 + 8'(cmd_pkg::COMP_BYTES * s_q.comp_n);
            s_d.tx_buf[cmd_pkg::POS_PAY] = 8'(s_q.comp_n);
            for (int i = 0; i < cmd_pkg::COMP_MAX; i++) begin
              if (i < int'(s_q.comp_n)) begin
                val = comp_value(s_q.comp_id[i], sample);
                s_d.tx_buf[cmd_pkg::POS_PAY+1+cmd_pkg::COMP_BYTES*i] = s_q.comp_id[i];
                for (int k = 0; k < 4; k++) begin
                  s_d.tx_buf[cmd_pkg::POS_PAY+2+cmd_pkg::COMP_BYTES*i+k] = val[8*(3-k) +: 8];
                end
              end
            end
          end
          cmd_pkg::ID_CFG_WRITE: begin
            if (mag_ok) begin
              s_d.sel.mag = cfg_low3;
            end
            if (accel_ok) begin
              s_d.sel.accel = cfg_low3;
            end
            rsp_send = mag_ok || accel_ok;
            rsp_id = cmd_pkg::ID_CFG_ACK;
          end
          cmd_pkg::ID_CFG_READ: begin
            // Other configuration items live outside this block and get no answer here.
            rsp_send = cfg_known;
            rsp_id = cmd_pkg::ID_CFG_RESP;
            rsp_len = cmd_pkg::LEN_CFG;
            s_d.tx_buf[cmd_pkg::POS_PAY] = cfg_id;
            s_d.tx_buf[cmd_pkg::POS_PAY+1] = 8'h00;
            s_d.tx_buf[cmd_pkg::POS_PAY+2] = 8'h00;
            s_d.tx_buf[cmd_pkg::POS_PAY+3] = 8'h00;
            s_d.tx_buf[cmd_pkg::POS_PAY+4] = {5'h00, (cfg_id == cmd_pkg::CFG_MAG_SET)
                                              ? s_q.sel.mag : s_q.sel.accel};
          end
          cmd_pkg::ID_PERSIST: s_d.persist = 1'b1;
          cmd_pkg::ID_SLEEP_REQ: begin
            rsp_send = 1'b1;
            rsp_id = cmd_pkg::ID_SLEEP_ACK;
            s_d.sleep_after = 1'b1;
          end
          default: ;
        endcase
      end
      cmd_pkg::S_TX: begin
        if (tx_ready) begin
          s_d.tx_idx = tx_nx;
          if (tx_nx == s_q.tx_len) begin
            s_d.st = s_q.sleep_after ? cmd_pkg::S_SLEEP : cmd_pkg::S_RX;
            // Power goes down only once the acknowledgement has fully left.
            s_d.awake = !s_q.sleep_after;
            s_d.sleep_after = 1'b0;
          end else if (tx_nx == s_q.tx_len - 8'h01) begin
            s_d.tx_byte = s_q.tx_crc[7:0];
          end else begin
            s_d.tx_crc = tx_crc_n;
            s_d.tx_byte = (tx_nx == s_q.tx_len - 8'h02) ? tx_crc_n[15:8] : s_q.tx_buf[tx_nx];
          end
        end
      end
      cmd_pkg::S_SLEEP: begin
        // The line idles high, so any low level is host activity.
        if (!s_q.rx_sync) begin
          s_d.awake = 1'b1;
          rsp_send = 1'b1;
          rsp_id = cmd_pkg::ID_WAKE_ACK;
        end
      end
      default: s_d.st = cmd_pkg::S_RX;
    endcase
    if (rsp_send) begin
      s_d.tx_buf[cmd_pkg::POS_LEN_HI] = 8'h00;
      s_d.tx_buf[cmd_pkg::POS_LEN_LO] = rsp_len;
      s_d.tx_buf[cmd_pkg::POS_ID] = rsp_id;
      s_d.tx_len = rsp_len;
      s_d.tx_idx = 8'h00;
      s_d.tx_byte = 8'h00;
      s_d.tx_crc = cmd_pkg::CRC_INIT;
      s_d.st = cmd_pkg::S_TX;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.st <= cmd_pkg::S_RX;
      s_q.awake <= 1'b1;
      s_q.rx_meta <= 1'b1;
      s_q.rx_sync <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tx_valid = (s_q.st == cmd_pkg::S_TX);
  assign tx_byte = s_q.tx_byte;
  assign sensors_on = s_q.awake;
  assign coeff_sel = s_q.sel;
  assign persist_strobe = s_q.persist;
  assign cal_store_strobe = s_q.cal_store;
  assign cal_store_set = s_q.cal_set;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence exec_of(logic [7:0] id);
    ce && s_q.st == cmd_pkg::S_EXEC && rx_id == id;
  endsequence
  sequence tx_frame(logic [7:0] id, logic [7:0] len);
    tx_valid && s_q.tx_buf[cmd_pkg::POS_ID] == id && s_q.tx_len == len && tx_byte == 8'h00;
  endsequence
  sequence wake_seen;
    ce && s_q.st == cmd_pkg::S_SLEEP && !s_q.rx_sync;
  endsequence

  power_off_a: assert property (s_q.st == cmd_pkg::S_SLEEP |->
    !sensors_on && !tx_valid)
    else $error("asleep with power on");
  sleep_ack_a: assert property (exec_of(cmd_pkg::ID_SLEEP_REQ) |=>
    tx_frame(cmd_pkg::ID_SLEEP_ACK, cmd_pkg::FRAME_OVERHEAD) && s_q.sleep_after)
    else $error("sleep request not confirmed");
  wake_up_a: assert property (wake_seen |=> sensors_on)
    else $error("no wake on receive activity");
  wake_ack_a: assert property (wake_seen |=>
    tx_frame(cmd_pkg::ID_WAKE_ACK, cmd_pkg::FRAME_OVERHEAD))
    else $error("wake not confirmed");
  mag_select_a: assert property (exec_of(cmd_pkg::ID_CFG_WRITE) ##0 mag_ok |=>
    coeff_sel.mag == $past(cfg_low3))
    else $error("magnetometer set not taken");
  cfg_ack_a: assert property (exec_of(cmd_pkg::ID_CFG_WRITE) ##0 (mag_ok || accel_ok)
    |=> tx_frame(cmd_pkg::ID_CFG_ACK, cmd_pkg::FRAME_OVERHEAD))
    else $error("config write not acknowledged");
  cfg_read_a: assert property (exec_of(cmd_pkg::ID_CFG_READ) ##0 cfg_known |=>
    tx_frame(cmd_pkg::ID_CFG_RESP, cmd_pkg::LEN_CFG)
    && s_q.tx_buf[cmd_pkg::POS_PAY] == $past(cfg_id))
    else $error("config read answer wrong");
  persist_a: assert property (exec_of(cmd_pkg::ID_PERSIST) |=> persist_strobe)
    else $error("save not started");
  cal_set_a: assert property (ce && cal_done |=>
    cal_store_strobe && cal_store_set == $past(s_q.sel.mag))
    else $error("calibration stored to wrong set");
  ident_rsp_a: assert property (exec_of(cmd_pkg::ID_IDENT_REQ) |=>
    tx_frame(cmd_pkg::ID_IDENT_RSP, cmd_pkg::FRAME_OVERHEAD + 8'(cmd_pkg::IDENT_LEN)))
    else $error("identification answer wrong");
  out_sel_a: assert property (exec_of(cmd_pkg::ID_OUT_SEL) ##0 sel_ok |=>
    s_q.comp_n == $past(cfg_id[cmd_pkg::CN_W-1:0]))
    else $error("component selection not taken");
  sample_rsp_a: assert property (exec_of(cmd_pkg::ID_SAMPLE_REQ) |=> tx_valid
    && s_q.tx_buf[cmd_pkg::POS_PAY] == 8'(s_q.comp_n)
    && s_q.tx_buf[cmd_pkg::POS_ID] == cmd_pkg::ID_SAMPLE_RSP)
    else $error("sample answer wrong");
  // The last byte taken must be the low checksum byte, and the frame must then end.
  frame_end_a: assert property (ce && tx_valid && tx_ready && tx_nx == s_q.tx_len |->
    tx_byte == s_q.tx_crc[7:0] && s_q.tx_buf[cmd_pkg::POS_LEN_LO] == s_q.tx_len ##1 !tx_valid)
    else $error("frame length and sent bytes disagree");
  accel_select_a: assert property (exec_of(cmd_pkg::ID_CFG_WRITE) ##0 accel_ok |=>
    coeff_sel.accel == $past(cfg_low3))
    else $error("accelerometer set not taken");
endmodule : compass_host_command_protocol

/* sim/host_model.sv */
// Host side of the compass command link: frames requests and collects the answers.
// Assumes the interpreter's clock and its byte-wide receive and transmit ports.
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] got [$];

  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
    tx_ready = 1'b0;
  end

  // Own bitwise checksum, kept apart from the design's so a shared slip cannot hide.
  function automatic logic [15:0] crc_of(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[k]) begin
      c = c ^ {b[k], 8'h00};
      for (int i = 0; i < 8; i++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_of

  function automatic void frame(input logic [7:0] id, input logic [7:0] pay [$],
                                output logic [7:0] f [$]);
    logic [15:0] c;
    f = {8'h00, 8'(pay.size() + 5), id};
    f = {f, pay};
    c = crc_of(f);
    f = {f, c[15:8], c[7:0]};
  endfunction : frame

  // The line is never left showing the last byte once its strobe has dropped.
  task automatic send(input logic [7:0] f [$]);
    foreach (f[k]) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_byte = f[k];
      @(negedge clock);
      rx_valid = 1'b0;
      rx_byte = ~f[k];
    end
  endtask : send

  // A byte is recorded where ready is raised; the next rising edge takes it.
  task automatic collect(input int limit);
    got.delete();
    for (int n = 0; n < limit; n++) begin
      @(negedge clock);
      if (tx_valid !== 1'b1 && got.size() > 0) begin
        break;
      end
      tx_ready = slow ? (n % 3 == 0) : 1'b1;
      if (tx_valid === 1'b1 && tx_ready) begin
        got.push_back(tx_byte);
      end
    end
    tx_ready = 1'b0;
  endtask : collect
endmodule : host_model

/* sim/compass_host_command_protocol_tb.sv */
// Self-checking bench of the compass host command interpreter.
// Assumes host_model stands on the byte link and the bench drives all other inputs.
`timescale 1ns/1ps
module compass_host_command_protocol_tb;
  typedef struct packed {
    logic [7:0] qid;
    logic [3:0] qn;
    logic [39:0] qpay;
    logic [7:0] aid;
    logic [3:0] an;
    logic [63:0] apay;
    logic [2:0] mag;
    logic [2:0] acc;
  } row_t;
  // Identification string; the value is arbitrary.
  localparam logic [63:0] ID_STR = 64'h5445535449443031;
  logic clock, rstn, rx_pin, rx_valid, tx_ready, cal_done, tx_valid, sensors_on;
  logic ce;
  logic persist_strobe, cal_store_strobe;
  logic [7:0] rx_byte, tx_byte;
  logic [2:0] cal_store_set;
  cmd_pkg::sample_t sample;
  cmd_pkg::coeff_sel_t coeff_sel;
  row_t rows [12];
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int persist_seen = 0;
  int cal_seen = 0;

  compass_host_command_protocol #(.IDENT(ID_STR)) DUT (
    .clock(clock), .rstn(rstn), .ce(ce), .rx_pin(rx_pin), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .sample(sample), .cal_done(cal_done),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .sensors_on(sensors_on), .coeff_sel(coeff_sel),
    .persist_strobe(persist_strobe), .cal_store_strobe(cal_store_strobe),
    .cal_store_set(cal_store_set)
  );
  host_model host (
    .clock(clock), .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready)
  );

  always #2.5 clock = ~clock;

  always @(negedge clock) begin
    persist_seen += (persist_strobe === 1'b1);
    cal_seen += (cal_store_strobe === 1'b1);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic match(input logic [7:0] ef [$]);
    check("frame length", 32'(host.got.size()), 32'(ef.size()));
    foreach (ef[k]) begin
      if (k < host.got.size()) begin
        check("frame byte", 32'(host.got[k]), 32'(ef[k]));
      end
    end
  endtask : match

  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    logic [7:0] q [$];
    logic [7:0] p [$];
    logic [7:0] f [$];
    logic [7:0] ef [$];
    logic [7:0] none [$];
    logic [127:0] sp;
    clock = 1'b0;
    rstn = 1'b0;
    rx_pin = 1'b1;
    ce = 1'b1;
    cal_done = 1'b0;
    sample = '0;
    rows[0] = '{8'h01, 4'h0, 40'h0, 8'h02, 4'h8, ID_STR, 3'h0, 3'h0};
    rows[1] = '{8'h06, 4'h5, 40'h1200000004, 8'h13, 4'h0, 64'h0, 3'h4, 3'h0};
    rows[2] = '{8'h07, 4'h1, 40'h1200000000, 8'h08, 4'h5, 64'h1200000004000000, 3'h4, 3'h0};
    rows[3] = '{8'h06, 4'h5, 40'h1300000002, 8'h13, 4'h0, 64'h0, 3'h4, 3'h2};
    rows[4] = '{8'h07, 4'h1, 40'h1300000000, 8'h08, 4'h5, 64'h1300000002000000, 3'h4, 3'h2};
    rows[5] = '{8'h06, 4'h5, 40'h1200000008, 8'h00, 4'h0, 64'h0, 3'h4, 3'h2};
    rows[6] = '{8'h06, 4'h5, 40'h1300000003, 8'h00, 4'h0, 64'h0, 3'h4, 3'h2};
    rows[7] = '{8'h06, 4'h5, 40'h1200000007, 8'h13, 4'h0, 64'h0, 3'h7, 3'h2};
    rows[8] = '{8'h03, 4'h4, 40'h0305181900, 8'h00, 4'h0, 64'h0, 3'h7, 3'h2};
    rows[9] = '{8'h04, 4'h0, 40'h0, 8'h05, 4'h0, 64'h0, 3'h7, 3'h2};
    rows[10] = '{8'h04, 4'h0, 40'h0, 8'h05, 4'h0, 64'h0, 3'h7, 3'h2};
    rows[11] = '{8'h09, 4'h0, 40'h0, 8'h00, 4'h0, 64'h0, 3'h7, 3'h2};
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    check("sensors_on", 32'(sensors_on), 32'h1);
    check("coeff_sel", 32'(coeff_sel), 32'h0);
    for (int i = 0; i < 12; i++) begin
      sample = {32'h43B3DF5E + 32'(i), 32'hBE88EDBD, 32'h3DB51553};
      host.slow = i[0];
      q.delete();
      p.delete();
      ef.delete();
      for (int k = 0; k < rows[i].qn; k++) begin
        q.push_back(rows[i].qpay[39-8*k -: 8]);
      end
      for (int k = 0; k < rows[i].an; k++) begin
        p.push_back(rows[i].apay[63-8*k -: 8]);
      end
      // Each poll carries a fresh sample, so a stale answer is caught.
      if (rows[i].qid == 8'h04) begin
        sp = {8'h03, 8'h05, sample.heading, 8'h18, sample.pitch, 8'h19, sample.roll};
        for (int k = 0; k < 16; k++) begin
          p.push_back(sp[127-8*k -: 8]);
        end
      end
      host.frame(rows[i].qid, q, f);
      host.send(f);
      host.collect(150);
      if (rows[i].aid != 8'h00) begin
        host.frame(rows[i].aid, p, ef);
      end
      match(ef);
      check("mag set", 32'(coeff_sel.mag), 32'(rows[i].mag));
      check("accel set", 32'(coeff_sel.accel), 32'(rows[i].acc));
    end
    check("persist pulses", 32'(persist_seen), 32'h1);
    host.frame(8'h01, none, f);
    f[4] = ~f[4];
    host.send(f);
    host.collect(150);
    ef.delete();
    match(ef);
    @(negedge clock);
    cal_done = 1'b1;
    @(negedge clock);
    cal_done = 1'b0;
    // The strobe stands for one cycle only, so it is looked at right after its edge.
    check("cal strobe", 32'(cal_store_strobe), 32'h1);
    check("cal set", 32'(cal_store_set), 32'h7);
    @(negedge clock);
    check("cal strobe end", 32'(cal_store_strobe), 32'h0);
    check("cal set held", 32'(cal_store_set), 32'h7);
    // With the clock enable low a calibration pulse must leave no trace.
    ce = 1'b0;
    cal_done = 1'b1;
    @(negedge clock);
    cal_done = 1'b0;
    check("frozen strobe", 32'(cal_store_strobe), 32'h0);
    ce = 1'b1;
    host.frame(8'h0F, none, f);
    host.send(f);
    host.collect(150);
    host.frame(8'h1C, none, ef);
    match(ef);
    repeat (4) @(negedge clock);
    check("sensors_on asleep", 32'(sensors_on), 32'h0);
    rx_pin = 1'b0;
    host.collect(150);
    rx_pin = 1'b1;
    check("sensors_on awake", 32'(sensors_on), 32'h1);
    host.frame(8'h17, none, ef);
    match(ef);
    check("cal pulses", 32'(cal_seen), 32'h1);
    rstn = 1'b0;
    @(negedge clock);
    check("reset coeff_sel", 32'(coeff_sel), 32'h0);
    check("reset tx_valid", 32'(tx_valid), 32'h0);
    rstn = 1'b1;
    results();
  end
endmodule : compass_host_command_protocol_tb
